// >>> hdl/pst_regs.svh
/*
 * constants of the pd mac self-test block: register offsets, field positions,
 * reset values and timing counts.
 * assumes inclusion by bare name from the design modules, the checker and the testbench.
 */
`ifndef PST_REGS_SVH
`define PST_REGS_SVH

// register indices as printed; the byte address is four times the index
`define PST_IDX_CTL_A        16'h1ac0
`define PST_IDX_CTL_B        16'h1ac1
`define PST_IDX_ERR_HI       16'h1ac2
`define PST_IDX_ERR_LO       16'h1ac3
`define PST_IDX_RX_STAT      16'h1ac7
`define PST_IDX_LINK_CTL     16'h1ac8
`define PST_ADDR_W           16

// control register a fields
`define PST_A_MODE_LSB       0
`define PST_A_EN             3
`define PST_A_RX_EN          4
`define PST_A_LOOPBACK       5
`define PST_A_AUTO_RSP       6
`define PST_MODE_CONT        3'h2

// control register b fields
`define PST_B_TX_START       0
`define PST_B_TX_RST         1
`define PST_B_CLR_ERR        2

// receive status fields
`define PST_S_DONE           0
`define PST_S_ERROR          1

// timing: bit time and frame length
`define PST_CLK_MHZ          100
`define PST_BIT_NS           3334
`define PST_BIT_CYC          ((`PST_BIT_NS * `PST_CLK_MHZ) / 1000)
`define PST_FRAME_BITS       16'h0100
`define PST_LFSR_SEED        16'hace1

`endif

// >>> hdl/pst_pkg.sv
/*
 * types of the self-test block.
 * assumes pst_regs.svh is on the include path.
 */
package pst_pkg;
    typedef enum logic [1:0] {PST_TX_IDLE, PST_TX_RUN, PST_TX_RSP} pst_tx_state_t;

    typedef struct packed {
        logic [15:0] lfsr_q;
        logic [15:0] bit_cnt_q;
        logic [15:0] div_q;
    } pst_prbs_state_t;
endpackage

// >>> hdl/pst_prbs_if.sv
/*
 * interface between the self-test top and its prbs bit engine.
 * assumes one clock domain, aclk.
 */
`timescale 1ns/1ns
interface pst_prbs_if;
    logic       seed;    // reload the sequence
    logic       step;    // advance one bit
    logic       bit_out; // current sequence bit
    modport eng (input seed, input step, output bit_out);
    modport usr (output seed, output step, input bit_out);
endinterface

// >>> hdl/pst_prbs.sv
/*
 * prbs generator: a 16-bit lfsr, x^16+x^14+x^13+x^11+1.
 * assumes seed and step are single-cycle strobes on aclk.
 */
`timescale 1ns/1ns
`include "pst_regs.svh"
module pst_prbs
    import pst_pkg::*;
(
    input  wire logic aclk,    // system clock
    input  wire logic aresetn, // synchronous reset, active low
    pst_prbs_if.eng   pif      // seed/step/bit
);
    logic [15:0] lfsr_q;
    logic [15:0] lfsr_d;

    // seed wins over step, so a reset never advances the sequence
    always_comb begin
        lfsr_d = lfsr_q;
        if (pif.seed) begin
            lfsr_d = `PST_LFSR_SEED;
        end else if (pif.step) begin
            lfsr_d = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lfsr_q <= `PST_LFSR_SEED;
        end else begin
            lfsr_q <= lfsr_d;
        end
    end

    assign pif.bit_out = lfsr_q[15];
endmodule

// >>> hdl/pst_selftest.sv
/*
 * self-test logic of a power delivery mac: prbs transmit, receive compare,
 * 16-bit error count, status flags, automatic error-count answer;
 * registers over axi4-lite.
 * assumes the line coder takes one bit per bit-time enable and the line
 * decoder delivers received bits as single-cycle strobes on aclk.
 */
// Function
// - writing one to clear-error-count zeroes both counter bytes; write-only bit.
// - transmit-reset one resets transmitter and generator; never stored, reads zero.
// - transmit-start never reseeds the generator; sequence continues across frames.
// - in continuous mode transmit-reset stops the transmitter within one bit time.
// - reset and start written together: reset wins, start is dropped.
// - bit 0 write launches a frame; read returns transmit-active.
// - mode selects endless transmission or exactly one frame.
// - in receive mode with auto-response set, the error-count message is sent.
// - error counter is 16-bit, read-only, reset zero; high then low register.
// - with loopback and receive enabled, transmitted bits are compared internally.
// - receive-done sets on a full frame and clears by writing one.
// - receive-error valid with done: zero clean, one on errors.
// - setting receive enable enables receiver, reseeds reference, clears counter.
// - self-test enable with loopback blocks data from the normal receive path.
`timescale 1ns/1ns
`include "pst_regs.svh"
module pst_selftest
    import pst_pkg::*;
#(
    parameter int BIT_CYC    = `PST_BIT_CYC,    // clock cycles per bit time
    parameter int FRAME_BITS = `PST_FRAME_BITS  // bits in one prbs frame
) (
    input  wire logic        aclk,          // 100 mhz clock
    input  wire logic        aresetn,       // synchronous reset, active low
    input  wire logic [31:0] s_axi_awaddr,  // write address
    input  wire logic        s_axi_awvalid, // write address valid
    output logic             s_axi_awready, // write address ready
    input  wire logic [31:0] s_axi_wdata,   // write data
    input  wire logic [3:0]  s_axi_wstrb,   // write strobes
    input  wire logic        s_axi_wvalid,  // write data valid
    output logic             s_axi_wready,  // write data ready
    output logic [1:0]       s_axi_bresp,   // write response
    output logic             s_axi_bvalid,  // write response valid
    input  wire logic        s_axi_bready,  // write response ready
    input  wire logic [31:0] s_axi_araddr,  // read address
    input  wire logic        s_axi_arvalid, // read address valid
    output logic             s_axi_arready, // read address ready
    output logic [31:0]      s_axi_rdata,   // read data
    output logic [1:0]       s_axi_rresp,   // read response
    output logic             s_axi_rvalid,  // read data valid
    input  wire logic        s_axi_rready,  // read data ready
    input  wire logic        rx_bit,        // decoded line bit
    input  wire logic        rx_bit_valid,  // strobe for rx_bit
    input  wire logic        rx_frame_end,  // decoder saw end of frame
    output logic             tx_bit,        // bit to the line coder
    output logic             tx_bit_valid,  // strobe, one per bit time
    output logic             tx_power_on,   // powers the line transmitter
    output logic             rx_func_bit_valid, // strobe to normal receive path
    output logic             rsp_send       // request error-count message
);
    localparam logic [15:0] BIT_CYC_W = 16'(BIT_CYC);
    localparam logic [15:0] FRAME_W   = 16'(FRAME_BITS);

    typedef struct packed {
        logic          awready;
        logic          wready;
        logic          bvalid;
        logic [1:0]    bresp;
        logic          arready;
        logic          rvalid;
        logic [1:0]    rresp;
        logic [31:0]   rdata;
        logic          aw_have;
        logic          w_have;
        logic [15:0]   aw_idx;
        logic [31:0]   wdata;
        logic [3:0]    wstrb;
        logic [7:0]    ctl_a;
        logic          link_tx_auto;
        pst_tx_state_t tx_st;
        logic [15:0]   div;
        logic [15:0]   tx_cnt;
        logic          tx_bit;
        logic          tx_valid;
        logic [15:0]   rx_cnt;
        logic [15:0]   err_cnt;
        logic          frame_err;
        logic          rx_done;
        logic          rx_error;
        logic          rsp;
        logic          func_valid;
    } st_t;

    st_t s_q;
    st_t s_d;

    pst_prbs_if tx_if ();
    pst_prbs_if rx_if ();

    pst_prbs u_tx_prbs (.aclk(aclk), .aresetn(aresetn), .pif(tx_if));
    pst_prbs u_rx_prbs (.aclk(aclk), .aresetn(aresetn), .pif(rx_if));

    // index from a byte address; unmapped addresses are decoded by the caller
    function automatic logic [15:0] idx_of(input logic [31:0] a);
        return a[17:2];
    endfunction

    function automatic logic mapped(input logic [15:0] i);
        return (i == `PST_IDX_CTL_A) || (i == `PST_IDX_CTL_B) || (i == `PST_IDX_ERR_HI) ||
               (i == `PST_IDX_ERR_LO) || (i == `PST_IDX_RX_STAT) || (i == `PST_IDX_LINK_CTL);
    endfunction

    logic        wr_go;
    logic        wr_b;
    logic        wr_a;
    logic        wr_s;
    logic [7:0]  wbyte;
    logic        tx_rst;
    logic        tx_start;
    logic        clr_err;
    logic        rx_en_rise;
    logic        en;
    logic        rx_en;
    logic        loop;
    logic        cont;
    logic        bit_tick;
    logic        in_bit;
    logic        in_valid;
    logic        rx_step;
    logic        mismatch;
    logic        frame_last;

    // write decode: a write completes when address and data are both held
    always_comb begin
        wr_go    = s_q.aw_have && s_q.w_have && !s_q.bvalid;
        wbyte    = s_q.wstrb[0] ? s_q.wdata[7:0] : 8'h00;
        wr_a     = wr_go && (s_q.aw_idx == `PST_IDX_CTL_A) && s_q.wstrb[0];
        wr_b     = wr_go && (s_q.aw_idx == `PST_IDX_CTL_B);
        wr_s     = wr_go && (s_q.aw_idx == `PST_IDX_RX_STAT);
        tx_rst   = wr_b && wbyte[`PST_B_TX_RST];
        tx_start = wr_b && wbyte[`PST_B_TX_START] && !tx_rst;
        clr_err  = wr_b && wbyte[`PST_B_CLR_ERR];
        rx_en_rise = wr_a && wbyte[`PST_A_RX_EN] && !s_q.ctl_a[`PST_A_RX_EN];
        en       = s_q.ctl_a[`PST_A_EN];
        rx_en    = s_q.ctl_a[`PST_A_RX_EN];
        loop     = s_q.ctl_a[`PST_A_LOOPBACK];
        cont     = s_q.ctl_a[2:0] == `PST_MODE_CONT;
        bit_tick = s_q.div == BIT_CYC_W - 16'h0001;
        frame_last = s_q.tx_cnt == FRAME_W - 16'h0001;
        // loopback feeds the transmitted bits back to the compare
        in_bit   = (loop && en) ? s_q.tx_bit : rx_bit;
        in_valid = (loop && en) ? s_q.tx_valid : rx_bit_valid;
        rx_step  = rx_en && in_valid && !rx_en_rise;
        mismatch = rx_step && (in_bit != rx_if.bit_out);
    end

    // generator strobes: only transmit-reset reseeds the transmit side
    assign tx_if.seed = tx_rst;
    assign tx_if.step = (s_q.tx_st == PST_TX_RUN) && bit_tick && !tx_rst;
    assign rx_if.seed = rx_en_rise;
    assign rx_if.step = rx_step;

    // next-state logic
    always_comb begin
        s_d = s_q;
        s_d.rsp = 1'b0;
        s_d.tx_valid = 1'b0;

        // write channel acceptance, either order
        s_d.awready = 1'b0;
        s_d.wready  = 1'b0;
        if (s_axi_awvalid && s_q.awready) begin
            s_d.aw_have = 1'b1;
            s_d.aw_idx  = idx_of(s_axi_awaddr);
        end else if (!s_q.aw_have && !s_axi_awvalid) begin
            s_d.awready = 1'b0;
        end
        if (s_axi_wvalid && s_q.wready) begin
            s_d.w_have = 1'b1;
            s_d.wdata  = s_axi_wdata;
            s_d.wstrb  = s_axi_wstrb;
        end
        if (!s_d.aw_have && s_axi_awvalid && !s_q.awready) begin
            s_d.awready = 1'b1;
        end
        if (!s_d.w_have && s_axi_wvalid && !s_q.wready) begin
            s_d.wready = 1'b1;
        end
        if (wr_go) begin
            s_d.bvalid  = 1'b1;
            s_d.bresp   = mapped(s_q.aw_idx) ? 2'b00 : 2'b10;
            s_d.aw_have = 1'b0;
            s_d.w_have  = 1'b0;
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end

        // read channel: one read at a time, answer two cycles after arvalid
        s_d.arready = 1'b0;
        if (s_axi_arvalid && !s_q.arready && !s_q.rvalid) begin
            s_d.arready = 1'b1;
        end
        if (s_axi_arvalid && s_q.arready) begin
            s_d.rvalid = 1'b1;
            s_d.rresp  = 2'b00;
            s_d.rdata  = 32'h0000_0000;
            unique case (idx_of(s_axi_araddr))
                `PST_IDX_CTL_A:    s_d.rdata[7:0] = s_q.ctl_a;
                // start and reset are not stored: bit 0 shows activity, bit 1 reads zero
                `PST_IDX_CTL_B:    s_d.rdata[0] = s_q.tx_st != PST_TX_IDLE;
                `PST_IDX_ERR_HI:   s_d.rdata[7:0] = s_q.err_cnt[15:8];
                `PST_IDX_ERR_LO:   s_d.rdata[7:0] = s_q.err_cnt[7:0];
                `PST_IDX_RX_STAT:  s_d.rdata[1:0] = {s_q.rx_error, s_q.rx_done};
                `PST_IDX_LINK_CTL: s_d.rdata[0] = s_q.link_tx_auto;
                default:           s_d.rresp = 2'b10;
            endcase
        end
        if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end

        // control register a; link control holds the auto-response enable
        if (wr_a) begin
            s_d.ctl_a = wbyte;
        end
        if (wr_go && (s_q.aw_idx == `PST_IDX_LINK_CTL) && s_q.wstrb[0]) begin
            s_d.link_tx_auto = wbyte[0];
        end

        // bit-time divider runs while transmitting
        if (s_q.tx_st == PST_TX_IDLE || bit_tick) begin
            s_d.div = 16'h0000;
        end else begin
            s_d.div = s_q.div + 16'h0001;
        end

        // transmitter
        unique case (s_q.tx_st)
            PST_TX_IDLE: begin
                if (tx_start && en) begin
                    s_d.tx_st  = PST_TX_RUN;
                    s_d.tx_cnt = 16'h0000;
                end
            end
            PST_TX_RUN: begin
                if (bit_tick) begin
                    s_d.tx_bit   = tx_if.bit_out;
                    s_d.tx_valid = 1'b1;
                    s_d.tx_cnt   = frame_last ? 16'h0000 : s_q.tx_cnt + 16'h0001;
                    if (frame_last && !cont) begin
                        s_d.tx_st = PST_TX_IDLE;
                    end
                end
            end
            PST_TX_RSP: begin
                s_d.tx_st = PST_TX_IDLE;
            end
        endcase
        // reset stops at once, well inside one bit time
        if (tx_rst || !en) begin
            s_d.tx_st  = PST_TX_IDLE;
            s_d.tx_cnt = 16'h0000;
            s_d.div    = 16'h0000;
        end

        // receive compare and frame end
        if (rx_step) begin
            s_d.rx_cnt = s_q.rx_cnt + 16'h0001;
            if (mismatch) begin
                s_d.frame_err = 1'b1;
                if (s_q.err_cnt != 16'hffff) begin
                    s_d.err_cnt = s_q.err_cnt + 16'h0001;
                end
            end
        end
        // clearing done happens before setting so a new frame end wins
        if (wr_s && wbyte[`PST_S_DONE]) begin
            s_d.rx_done = 1'b0;
        end
        if (rx_en && ((rx_step && s_q.rx_cnt == FRAME_W - 16'h0001) || (!loop && rx_frame_end))) begin
            s_d.rx_done   = 1'b1;
            s_d.rx_error  = s_q.frame_err || mismatch;
            s_d.rx_cnt    = 16'h0000;
            s_d.frame_err = 1'b0;
            s_d.rsp       = s_q.ctl_a[`PST_A_AUTO_RSP] || s_q.link_tx_auto;
        end
        if (clr_err || rx_en_rise) begin
            s_d.err_cnt = 16'h0000;
        end
        if (rx_en_rise) begin
            s_d.rx_cnt    = 16'h0000;
            s_d.frame_err = 1'b0;
        end

        // normal receive path blocked during loopback self-test
        s_d.func_valid = rx_bit_valid && !(en && loop);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
            s_q.tx_st <= PST_TX_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign s_axi_awready     = s_q.awready;
    assign s_axi_wready      = s_q.wready;
    assign s_axi_bresp       = s_q.bresp;
    assign s_axi_bvalid      = s_q.bvalid;
    assign s_axi_arready     = s_q.arready;
    assign s_axi_rdata       = s_q.rdata;
    assign s_axi_rresp       = s_q.rresp;
    assign s_axi_rvalid      = s_q.rvalid;
    assign tx_bit            = s_q.tx_bit;
    assign tx_bit_valid      = s_q.tx_valid;
    assign tx_power_on       = s_q.ctl_a[`PST_A_EN];
    assign rx_func_bit_valid = s_q.func_valid;
    assign rsp_send          = s_q.rsp;
endmodule

// >>> tb/pst_selftest_asserts.sv
/* checker of the self-test block: bus answers, bit pacing, stop after reset, path blocking.
   assumes binding into pst_selftest with its bit-time parameter handed on. */
`timescale 1ns/1ns
`include "pst_regs.svh"
module pst_selftest_asserts #(
    parameter int BIT_CYC = 4 // cycles per bit time
) (
    input wire logic        aclk,              // clock
    input wire logic        aresetn,           // reset, active low
    input wire logic [31:0] s_axi_awaddr,      // aw addr
    input wire logic        s_axi_awvalid,     // aw valid
    input wire logic        s_axi_awready,     // aw ready
    input wire logic [31:0] s_axi_wdata,       // w data
    input wire logic        s_axi_wvalid,      // w valid
    input wire logic        s_axi_wready,      // w ready
    input wire logic        s_axi_bvalid,      // b valid
    input wire logic        s_axi_arvalid,     // ar valid
    input wire logic        s_axi_arready,     // ar ready
    input wire logic [31:0] s_axi_rdata,       // r data
    input wire logic        s_axi_rvalid,      // r valid
    input wire logic        tx_bit_valid,      // bit strobe
    input wire logic        tx_power_on,       // transmitter power
    input wire logic        rx_bit_valid,      // line bit strobe
    input wire logic        rx_func_bit_valid, // normal path strobe
    input wire logic        rsp_send           // answer request
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // cycles since the last bit strobe
    logic [15:0] gap_q;
    logic        seen_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gap_q  <= 16'h0000;
            seen_q <= 1'b0;
        end else if (tx_bit_valid) begin
            gap_q  <= 16'h0001;
            seen_q <= 1'b1;
        end else if (gap_q != 16'hffff) begin
            gap_q <= gap_q + 16'h0001;
        end
    end

    // write taken, transmit reset written, line quiet
    sequence aw_w_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence tx_rst_write;
        aw_w_taken ##0 (s_axi_awaddr[17:2] == `PST_IDX_CTL_B && s_axi_wdata[`PST_B_TX_RST]);
    endsequence
    sequence quiet_line;
        !tx_bit_valid [*8];
    endsequence

    tx_spacing_a: assert property (tx_bit_valid && seen_q |-> gap_q >= BIT_CYC)
        else $error("bit strobes closer than one bit time");
    tx_powered_a: assert property (tx_bit_valid |-> tx_power_on)
        else $error("bit sent with transmitter unpowered");
    tx_stop_a: assert property (tx_rst_write |-> ##4 quiet_line)
        else $error("bits sent after transmit reset");
    wr_answer_a: assert property (aw_w_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    byte_lane_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("read data above byte lane");
    func_block_a: assert property (rx_func_bit_valid |-> $past(rx_bit_valid))
        else $error("normal path strobe without line strobe");
    rsp_pulse_a: assert property (rsp_send |=> !rsp_send)
        else $error("answer request longer than one cycle");
endmodule

bind pst_selftest pst_selftest_asserts #(.BIT_CYC(BIT_CYC)) u_pst_selftest_asserts (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .tx_bit_valid, .tx_power_on, .rx_bit_valid, .rx_func_bit_valid, .rsp_send
);

// >>> tb/pst_line_partner.sv
/* line partner: a tester that echoes every transmitted bit back, corrupting chosen bits.
   assumes one bit strobe per bit time from the block on aclk. */
`timescale 1ns/1ns
module pst_line_partner (
    input  wire logic       aclk,         // clock
    input  wire logic       tx_bit,       // bit from the block
    input  wire logic       tx_bit_valid, // its strobe
    input  wire logic [7:0] flip,         // bits of a frame to corrupt
    output logic            rx_bit,       // echoed bit
    output logic            rx_bit_valid, // echo strobe
    output int              n_tx          // bits seen
);
    initial begin
        rx_bit = 1'b0;
        rx_bit_valid = 1'b0;
        n_tx = 0;
    end
    // echo one cycle later; between bits the line toggles so stale data never passes
    always @(posedge aclk) begin
        rx_bit_valid <= tx_bit_valid;
        if (tx_bit_valid) begin
            rx_bit <= tx_bit ^ flip[n_tx % 8];
            n_tx   <= n_tx + 1;
        end else begin
            rx_bit <= ~rx_bit;
        end
    end
endmodule

// >>> tb/pst_selftest_tb.sv
/* testbench of the self-test block: bus master, echo partner, results checked through queues.
   assumes design, header, partner and checker compiled first. */
`timescale 1ns/1ns
`include "pst_regs.svh"
module pst_selftest_tb;
    localparam int BC = 4;
    localparam int FB = 8;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        rx_bit, rx_bit_valid, rx_frame_end, tx_bit, tx_bit_valid, tx_power_on, rx_func_bit_valid, rsp_send;
    logic [7:0]  flip;
    int          fails, n_checks, n_tx, n_rsp, n_func;
    logic [33:0] rq[$];
    logic [1:0]  bq[$];

    pst_selftest #(.BIT_CYC(BC), .FRAME_BITS(FB)) u_pst_selftest (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .rx_bit, .rx_bit_valid, .rx_frame_end, .tx_bit, .tx_bit_valid, .tx_power_on, .rx_func_bit_valid,
        .rsp_send
    );
    pst_line_partner u_pst_line_partner (.aclk, .tx_bit, .tx_bit_valid, .flip, .rx_bit, .rx_bit_valid, .n_tx);

    always #5 aclk = ~aclk;

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic bad(input string m);
        fails++;
        $display("mismatch at %0t: %s", $time, m);
    endtask
    task automatic chk_rd(input logic [1:0] r, input logic [31:0] d);
        logic [33:0] x;
        x = (rq.size() > 0) ? rq.pop_front() : 'x;
        n_checks++;
        if ({r, d} !== x) bad($sformatf("read %h wanted %h", {r, d}, x));
    endtask
    task automatic chk_b(input logic [1:0] r);
        logic [1:0] x;
        x = (bq.size() > 0) ? bq.pop_front() : 'x;
        n_checks++;
        if (r !== x) bad($sformatf("bresp %h wanted %h", r, x));
    endtask
    task automatic chk_n(input int got, input int want);
        n_checks++;
        if (got != want) bad($sformatf("count %0d wanted %0d", got, want));
    endtask

    // watcher: bus answers against the oldest note, plus event tallies
    always @(posedge aclk) begin
        if (s_axi_rvalid && s_axi_rready) chk_rd(s_axi_rresp, s_axi_rdata);
        if (s_axi_bvalid && s_axi_bready) chk_b(s_axi_bresp);
        if (rsp_send) n_rsp++;
        if (rx_func_bit_valid) n_func++;
    end

    // register write; upper data lanes carry random filler
    task automatic wr(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] e = 2'b00);
        bq.push_back(e);
        @(posedge aclk);
        s_axi_awaddr  <= {14'h0000, idx, 2'b00};
        s_axi_wdata   <= {24'($urandom()), d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        fork
            begin
                do @(posedge aclk); while (!s_axi_awready);
                s_axi_awvalid <= 1'b0;
            end
            begin
                do @(posedge aclk); while (!s_axi_wready);
                s_axi_wvalid <= 1'b0;
            end
        join
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] e = 2'b00);
        rq.push_back({e, 24'h000000, d});
        @(posedge aclk);
        s_axi_araddr  <= {14'h0000, idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask
    task automatic wait_tx(input int n);
        int k;
        k = 0;
        while (n_tx < n && k < 500) begin
            @(posedge aclk);
            k++;
        end
    endtask
    // one frame: start, check status while busy, bit counts, then status and count
    task automatic frame(input logic [7:0] f, input logic [7:0] e, input int fw);
        int t0, f0;
        t0 = n_tx;
        f0 = n_func;
        flip <= f;
        wr(`PST_IDX_CTL_B, 8'h01);
        rd(`PST_IDX_CTL_B, 8'h01);
        wait_tx(t0 + FB);
        repeat (3 * BC) @(posedge aclk);
        chk_n(n_tx - t0, FB);
        chk_n(n_func - f0, fw);
        rd(`PST_IDX_RX_STAT, {6'h00, e != 8'h00, 1'b1});
        rd(`PST_IDX_ERR_LO, e);
        rd(`PST_IDX_CTL_B, 8'h00);
        wr(`PST_IDX_RX_STAT, 8'h01);
        rd(`PST_IDX_RX_STAT, {6'h00, e != 8'h00, 1'b0});
    endtask

    // main sequence
    initial begin
        int         e;
        logic [7:0] f;
        aclk = 1'b0;
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        s_axi_awaddr = 32'h00000000;
        s_axi_wdata = 32'h00000000;
        s_axi_araddr = 32'h00000000;
        s_axi_wstrb = 4'h1;
        rx_frame_end = 1'b0;
        flip = 8'h00;
        void'($urandom(82673));
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`PST_IDX_CTL_B, 8'h00);
        rd(`PST_IDX_ERR_HI, 8'h00);
        rd(`PST_IDX_ERR_LO, 8'h00);
        rd(`PST_IDX_RX_STAT, 8'h00);
        rd(16'h1ac5, 8'h00, 2'b10);
        wr(16'h1ac5, 8'h5a, 2'b10);
        wr(`PST_IDX_CTL_A, 8'h18);
        rd(`PST_IDX_CTL_A, 8'h18);
        repeat (500) @(posedge aclk);
        wr(`PST_IDX_CTL_B, 8'h02);
        repeat (16) @(posedge aclk);
        frame(8'h00, 8'h00, FB);
        f = 8'($urandom()) | 8'h01;
        wr(`PST_IDX_CTL_A, 8'h58);
        frame(f, 8'($countones(f)), FB);
        chk_n(n_rsp, 1);
        rd(`PST_IDX_ERR_HI, 8'h00);
        e = n_tx;
        wr(`PST_IDX_CTL_B, 8'h03);
        repeat (40) @(posedge aclk);
        chk_n(n_tx, e);
        wr(`PST_IDX_CTL_A, 8'h08);
        wr(`PST_IDX_CTL_A, 8'h18);
        wr(`PST_IDX_LINK_CTL, 8'h01);
        rd(`PST_IDX_LINK_CTL, 8'h01);
        f = 8'($urandom()) | 8'h80;
        frame(f, 8'($countones(f)), FB);
        chk_n(n_rsp, 2);
        wr(`PST_IDX_LINK_CTL, 8'h00);
        wr(`PST_IDX_CTL_B, 8'h04);
        rd(`PST_IDX_ERR_LO, 8'h00);
        rd(`PST_IDX_CTL_B, 8'h00);
        wr(`PST_IDX_CTL_A, 8'h38);
        frame(8'hff, 8'h00, 0);
        wr(`PST_IDX_CTL_A, 8'h0a);
        e = n_tx;
        wr(`PST_IDX_CTL_B, 8'h01);
        wait_tx(e + 2 * FB + 4);
        chk_n(int'(n_tx >= e + 2 * FB + 4), 1);
        wr(`PST_IDX_CTL_B, 8'h02);
        repeat (BC) @(posedge aclk);
        e = n_tx;
        repeat (40) @(posedge aclk);
        chk_n(n_tx, e);
        wr(`PST_IDX_CTL_A, 8'h00);
        repeat (4) @(posedge aclk);
        complete_run();
    end

    // watchdog sized well past the expected run of about eleven hundred cycles
    initial begin
        repeat (20000) @(posedge aclk);
        bad("watchdog expired");
        complete_run();
    end
endmodule
